// >>> verilog/down_timer_pkg.sv
// register map, field positions and state types of the two down-timer channels
// assumes a 32-bit avalon-mm slave with byte addresses; only byte lane 0 carries write data, count and duty reads also use bits 9:8
package down_timer_pkg;
   // register offsets; per-channel ones repeat at n * 0x20, shared and interrupt registers from 0x40
   localparam logic [6:0] OFS_CTRL_A = 7'h00;
   localparam logic [6:0] OFS_CTRL_B = 7'h04;
   localparam logic [6:0] OFS_RELOAD = 7'h08;
   localparam logic [6:0] OFS_DUTY = 7'h0C;
   localparam logic [6:0] OFS_TONE = 7'h10;
   localparam logic [6:0] OFS_PSC = 7'h14;
   localparam logic [6:0] OFS_SHARED_HIGH = 7'h40;
   localparam logic [6:0] OFS_CH3_HIGH = 7'h44;
   localparam logic [6:0] OFS_IRQ_FLAG = 7'h48;
   localparam logic [6:0] OFS_IRQ_EN = 7'h4C;
   localparam logic [6:0] OFS_IRQ_SECOND = 7'h50;
   // control a fields
   localparam int A_EN = 0;
   localparam int A_RELOAD_SEL = 1;
   localparam int A_ONE_SHOT = 2;
   localparam int A_FAST = 3;
   localparam int A_ACT_LOW = 6;
   localparam int A_WAVE_EN = 7;
   // control b fields
   localparam int B_RATIO = 0;
   localparam int B_PSC_N = 3;
   localparam int B_EDGE = 4;
   localparam int B_SRC = 5;
   localparam int B_HALF = 6;
   // tone control fields
   localparam int T_RATIO = 0;
   localparam int T_SEL_TIMER = 3;
   localparam int T_EN = 7;
   // upper bits in the high registers
   localparam int HI2_RLD = 6;
   localparam int HI2_DUTY = 2;
   localparam int HI3_RLD = 4;
   localparam int HI3_DUTY = 0;
   // interrupt register bits, then counter restart value and pin enable reset level
   localparam int IRQ2_FLAG = 5;
   localparam int IRQ2_EN = 5;
   localparam int GIE_BIT = 7;
   localparam int IRQ3_FLAG = 4;
   localparam int IRQ3_EN = 0;
   localparam logic [9:0] COUNT_ALL = 10'h3FF;
   localparam logic PIN_OE_N_RST = 1'b1;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] tone_ctl;
      logic [9:0] reload;
      logic [9:0] duty_pend;
      logic [9:0] duty;
      logic [9:0] count;
      logic [7:0] presc;
      logic [7:0] tdiv;
      logic stopped;
      logic flag;
      logic irq_en;
      logic irq;
      logic hold;
      logic was_act;
      logic tone;
      logic pin;
      logic pin_oe_n;
   } ch_t;

   typedef struct packed {
      ch_t [1:0] ch;
      logic [7:0] shared_high;
      logic [7:0] ch3_high;
      logic global_irq_enable;
      logic ack;
      logic [31:0] rdata;
      logic ext_s1;
      logic ext_s2;
      logic ext_prev;
      logic osc_s1;
      logic osc_s2;
      logic osc_prev;
   } state_t;
endpackage

// >>> verilog/down_timer_pwm_buzzer.sv
// two 10-bit down-timer channels with prescaler, pwm and tone outputs
// assumes ref_clk is the instruction clock; ext pin and fast osc are asynchronous
//
// What this block does
// - 10-bit prescaled down counter, double-buffered reload
// - high bits first; reload at underflow when enabled
// - disabled channel: low write loads counter
// - timer read returns live count
// - counting only while enable bit set
// - fast osc, else instruction clock or pin
// - edge select: 1 falling, 0 rising
// - prescaler active when enable_n 0, 1:2..1:256
// - prescaler count readable per channel
// - one-shot counts to zero once, stops
// - free-run restarts at reload or 0x3FF
// - channel two flag, irq, clear by 0
// - channel three flag and enable elsewhere
// - wave enable drives pin as output
// - polarity bit 1 active low
// - duty counts active clocks, zero never
// - duty high bits first, applied at underflow
// - tone enable drives pin as output
// - tone source bit and division 1:2..1:256
// - half step (channel three, fast osc only) adds half osc period
// - channel three high bits register layout
`timescale 1ns/100ps
module down_timer_pwm_buzzer
   import down_timer_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [6:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic ext_count_pin,
   input wire logic internal_fast_osc,
   output logic ch2_pin,
   output logic ch2_pin_oe_n,
   output logic ch3_pin,
   output logic ch3_pin_oe_n,
   output logic ch2_irq,
   output logic ch3_irq
);
   state_t s;
   state_t next_s;
   logic [1:0] uf_v;
   logic [1:0] pwm_v;
   logic wr_any;

   // all next-state logic; channels share one loop body
   always_comb begin
      logic ext_rise, ext_fall, osc_rise, osc_fall;
      logic sel, en, fast, src, psc_out, tick, uf, act, half, tpulse, clr;
      logic [6:0] lo;
      logic [7:0] pm, tm, wd;
      logic [1:0] rhi, dhi;
      ext_rise = 1'b0;
      ext_fall = 1'b0;
      osc_rise = 1'b0;
      osc_fall = 1'b0;
      sel = 1'b0;
      en = 1'b0;
      fast = 1'b0;
      src = 1'b0;
      psc_out = 1'b0;
      tick = 1'b0;
      uf = 1'b0;
      act = 1'b0;
      half = 1'b0;
      tpulse = 1'b0;
      clr = 1'b0;
      lo = {2'b00, address[4:0]};
      pm = 8'h00;
      tm = 8'h00;
      wd = writedata[7:0];
      rhi = 2'b00;
      dhi = 2'b00;
      uf_v = 2'b00;
      pwm_v = 2'b00;
      next_s = s;
      // two-flop synchronisers, edges from the second stage only
      next_s.ext_s1 = ext_count_pin;
      next_s.ext_s2 = s.ext_s1;
      next_s.ext_prev = s.ext_s2;
      next_s.osc_s1 = internal_fast_osc;
      next_s.osc_s2 = s.osc_s1;
      next_s.osc_prev = s.osc_s2;
      ext_rise = s.ext_s2 & ~s.ext_prev;
      ext_fall = ~s.ext_s2 & s.ext_prev;
      osc_rise = s.osc_s2 & ~s.osc_prev;
      osc_fall = ~s.osc_s2 & s.osc_prev;
      // one wait cycle per access, write lands when waitrequest is low
      next_s.ack = (read | write) & ~s.ack;
      wr_any = s.ack & write & byteenable[0];
      if (wr_any && address == OFS_SHARED_HIGH) begin
         next_s.shared_high = wd;
      end
      if (wr_any && address == OFS_CH3_HIGH) begin
         next_s.ch3_high = wd;
      end
      if (wr_any && address == OFS_IRQ_EN) begin
         next_s.global_irq_enable = wd[GIE_BIT];
         next_s.ch[0].irq_en = wd[IRQ2_EN];
      end
      if (wr_any && address == OFS_IRQ_SECOND) begin
         next_s.ch[1].irq_en = wd[IRQ3_EN];
      end
      // read mux, sampled when the access is first seen
      if (read && !s.ack) begin
         next_s.rdata = 32'h0000_0000;
         case (address)
            OFS_SHARED_HIGH: next_s.rdata[7:0] = s.shared_high;
            OFS_CH3_HIGH: next_s.rdata[7:0] = s.ch3_high;
            OFS_IRQ_FLAG: next_s.rdata[IRQ2_FLAG] = s.ch[0].flag;
            OFS_IRQ_EN: begin
               next_s.rdata[GIE_BIT] = s.global_irq_enable;
               next_s.rdata[IRQ2_EN] = s.ch[0].irq_en;
            end
            OFS_IRQ_SECOND: begin
               next_s.rdata[IRQ3_FLAG] = s.ch[1].flag;
               next_s.rdata[IRQ3_EN] = s.ch[1].irq_en;
            end
            default: begin
               for (int j = 0; j < 2; j++) begin
                  if (address[6:5] == 2'(j)) begin
                     case (lo)
                        OFS_CTRL_A: next_s.rdata[7:0] = s.ch[j].ctrl_a;
                        OFS_CTRL_B: next_s.rdata[7:0] = s.ch[j].ctrl_b;
                        OFS_RELOAD: next_s.rdata[9:0] = s.ch[j].count;
                        OFS_DUTY: next_s.rdata[9:0] = s.ch[j].duty_pend;
                        OFS_TONE: next_s.rdata[7:0] = s.ch[j].tone_ctl;
                        OFS_PSC: next_s.rdata[7:0] = s.ch[j].presc;
                        default: next_s.rdata = 32'h0000_0000;
                     endcase
                  end
               end
            end
         endcase
      end
      for (int i = 0; i < 2; i++) begin
         sel = wr_any && address[6:5] == 2'(i);
         rhi = (i == 0) ? s.shared_high[HI2_RLD +: 2] : s.ch3_high[HI3_RLD +: 2];
         dhi = (i == 0) ? s.shared_high[HI2_DUTY +: 2] : s.ch3_high[HI3_DUTY +: 2];
         if (sel && lo == OFS_CTRL_A) begin
            next_s.ch[i].ctrl_a = wd;
         end
         if (sel && lo == OFS_CTRL_B) begin
            next_s.ch[i].ctrl_b = wd;
         end
         if (sel && lo == OFS_TONE) begin
            next_s.ch[i].tone_ctl = wd;
         end
         en = s.ch[i].ctrl_a[A_EN];
         fast = s.ch[i].ctrl_a[A_FAST];
         src = fast ? osc_rise : (s.ch[i].ctrl_b[B_SRC] ? (s.ch[i].ctrl_b[B_EDGE] ? ext_fall : ext_rise) : 1'b1);
         // ratio mask, divide by 2 to 256
         pm = 8'hFF >> (3'd7 - s.ch[i].ctrl_b[B_RATIO +: 3]);
         psc_out = src & ((s.ch[i].presc & pm) == pm);
         if (!en || s.ch[i].ctrl_b[B_PSC_N]) begin
            next_s.ch[i].presc = 8'h00;
         end else if (src) begin
            next_s.ch[i].presc = s.ch[i].presc + 8'h01;
         end
         tick = en & ~s.ch[i].stopped & (s.ch[i].ctrl_b[B_PSC_N] ? src : psc_out);
         uf = tick & (s.ch[i].count == 10'h000);
         uf_v[i] = uf;
         if (!en) begin
            next_s.ch[i].stopped = 1'b0;
         end
         // buffered reload from high bits and low byte
         if (sel && lo == OFS_RELOAD) begin
            next_s.ch[i].reload = {rhi, wd};
            next_s.ch[i].stopped = 1'b0;
         end
         if (sel && lo == OFS_RELOAD && !en) begin
            next_s.ch[i].count = {rhi, wd};
         end else if (uf) begin
            if (s.ch[i].ctrl_a[A_ONE_SHOT]) begin
               next_s.ch[i].stopped = 1'b1;
            end else if (s.ch[i].ctrl_a[A_RELOAD_SEL]) begin
               next_s.ch[i].count = s.ch[i].reload;
            end else begin
               next_s.ch[i].count = COUNT_ALL;
            end
         end else if (tick) begin
            next_s.ch[i].count = s.ch[i].count - 10'h001;
         end
         if (sel && lo == OFS_DUTY) begin
            next_s.ch[i].duty_pend = {dhi, wd};
         end
         if (uf) begin
            next_s.ch[i].duty = s.ch[i].duty_pend;
         end
         // active for duty clocks, zero never
         act = s.ch[i].count < s.ch[i].duty;
         next_s.ch[i].was_act = act;
         // stretch to the next osc edge after the fall
         half = (i == 1) && fast && s.ch[i].ctrl_b[B_HALF];
         if (half && s.ch[i].was_act && !act) begin
            next_s.ch[i].hold = 1'b1;
         end else if (!half || osc_rise || osc_fall) begin
            next_s.ch[i].hold = 1'b0;
         end
         // polarity; was_act bridges the cycle before hold is set, else the stretch has a gap
         pwm_v[i] = (act | s.ch[i].hold | (half & s.ch[i].was_act)) ^ s.ch[i].ctrl_a[A_ACT_LOW];
         tpulse = s.ch[i].tone_ctl[T_SEL_TIMER] ? uf : psc_out;
         tm = 8'h7F >> (3'd7 - s.ch[i].tone_ctl[T_RATIO +: 3]);
         if (!s.ch[i].tone_ctl[T_EN]) begin
            next_s.ch[i].tdiv = 8'h00;
            next_s.ch[i].tone = 1'b0;
         end else if (tpulse) begin
            next_s.ch[i].tdiv = s.ch[i].tdiv + 8'h01;
            if ((s.ch[i].tdiv & tm) == tm) begin
               next_s.ch[i].tone = ~s.ch[i].tone;
            end
         end
         // pwm first, pin turned to output
         if (s.ch[i].ctrl_a[A_WAVE_EN]) begin
            next_s.ch[i].pin = pwm_v[i];
         end else if (s.ch[i].tone_ctl[T_EN]) begin
            next_s.ch[i].pin = s.ch[i].tone;
         end else begin
            next_s.ch[i].pin = 1'b0;
         end
         next_s.ch[i].pin_oe_n = ~(s.ch[i].ctrl_a[A_WAVE_EN] | s.ch[i].tone_ctl[T_EN]);
         // flag, set beats a clearing write
         clr = (i == 0) ? (wr_any && address == OFS_IRQ_FLAG && !wd[IRQ2_FLAG]) :
            (wr_any && address == OFS_IRQ_SECOND && !wd[IRQ3_FLAG]);
         next_s.ch[i].flag = uf | (s.ch[i].flag & ~clr);
      end
      // interrupt request needs both enables
      for (int k = 0; k < 2; k++) begin
         next_s.ch[k].irq = next_s.ch[k].flag & next_s.ch[k].irq_en & next_s.global_irq_enable;
      end
   end

   // single state register; pins released at reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s <= '0;
         s.ch[0].pin_oe_n <= PIN_OE_N_RST;
         s.ch[1].pin_oe_n <= PIN_OE_N_RST;
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from state flops
   assign readdata = s.rdata;
   assign waitrequest = ~s.ack;
   assign ch2_pin = s.ch[0].pin;
   assign ch2_pin_oe_n = s.ch[0].pin_oe_n;
   assign ch3_pin = s.ch[1].pin;
   assign ch3_pin_oe_n = s.ch[1].pin_oe_n;
   assign ch2_irq = s.ch[0].irq;
   assign ch3_irq = s.ch[1].irq;

   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   // disabled low write lands in counter
   reload_load_a: assert property (
      wr_any && address == OFS_RELOAD && !s.ch[0].ctrl_a[A_EN] |=> s.ch[0].count == s.ch[0].reload)
      else $error("reload not loaded while disabled");
   // no counting while disabled
   count_hold_a: assert property (
      !s.ch[1].ctrl_a[A_EN] && !wr_any |=> $stable(s.ch[1].count))
      else $error("counter moved while disabled");
   // underflow sets the flag
   flag_set_a: assert property (
      uf_v[0] |=> s.ch[0].flag)
      else $error("channel two flag missed");
   flag_ch3_a: assert property (
      uf_v[1] |=> s.ch[1].flag ##1 (s.ch[1].flag || $past(wr_any)))
      else $error("channel three flag missed");
   // free run without reload restarts at all ones
   free_restart_a: assert property (
      uf_v[0] && !s.ch[0].ctrl_a[A_ONE_SHOT] && !s.ch[0].ctrl_a[A_RELOAD_SEL] && !wr_any
      |=> s.ch[0].count == COUNT_ALL)
      else $error("free run restart wrong");
   // one shot parks at zero
   one_shot_a: assert property (
      uf_v[1] && s.ch[1].ctrl_a[A_ONE_SHOT] && !wr_any |=> s.ch[1].stopped && s.ch[1].count == 10'h000)
      else $error("one shot did not stop");
   // staged duty moves at underflow
   duty_apply_a: assert property (
      uf_v[0] |=> s.ch[0].duty == $past(s.ch[0].duty_pend))
      else $error("duty not applied at underflow");
   // pwm has the pin whenever enabled
   pin_prio_a: assert property (
      s.ch[0].ctrl_a[A_WAVE_EN] |=> s.ch[0].pin == $past(pwm_v[0]) && !s.ch[0].pin_oe_n)
      else $error("pwm lost the pin");
   // access answered after exactly one wait cycle
   bus_wait_a: assert property (
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("waitrequest timing wrong");
endmodule

// >>> sim/tb_top.sv
// bench for the two down-timer channels: bus tasks, then scenario sequence
// assumes the design package and the top module compile before this file
`timescale 1ns/100ps
module tb_top
   import down_timer_pkg::*;
;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] address = 7'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic ext_count_pin = 1'b0;
   logic internal_fast_osc = 1'b0;
   logic [31:0] readdata;
   logic waitrequest;
   logic ch2_pin;
   logic ch2_pin_oe_n;
   logic ch3_pin;
   logic ch3_pin_oe_n;
   logic ch2_irq;
   logic ch3_irq;
   int errors = 0;
   int n_compared = 0;
   int hi;
   int tg;
   int cnt;
   logic [31:0] q;
   logic [31:0] prev_q;

   // 125 mhz instruction clock
   always #4 ref_clk = ~ref_clk;

   down_timer_pwm_buzzer i_down_timer_pwm_buzzer (.ref_clk(ref_clk), .sys_rst(sys_rst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .ext_count_pin(ext_count_pin), .internal_fast_osc(internal_fast_osc),
      .ch2_pin(ch2_pin), .ch2_pin_oe_n(ch2_pin_oe_n), .ch3_pin(ch3_pin), .ch3_pin_oe_n(ch3_pin_oe_n),
      .ch2_irq(ch2_irq), .ch3_irq(ch3_irq));

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, seen);
         errors++;
      end
   endtask

   // one avalon access; held until waitrequest is sampled low, bounded wait
   task automatic bus(input logic wr, input logic [6:0] a, input logic [7:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge ref_clk);
      address <= a;
      write <= wr;
      read <= ~wr;
      writedata <= {24'h00_0000, d};
      byteenable <= be;
      do begin
         @(posedge ref_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 64);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      if (waitrequest !== 1'b0) begin
         errors++;
         $display("unexpected waitrequest expected 0 seen 1");
         wrap_up();
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input logic [6:0] a);
      bus(1'b0, a, 8'h00, 4'hF);
   endtask

   // high bits first, then low bytes; b is the channel base
   task automatic load(input logic [6:0] b, input logic [9:0] r, input logic [9:0] d);
      if (b == 7'h00)
         wr(OFS_SHARED_HIGH, {r[9:8], 2'b00, d[9:8], 2'b00});
      else
         wr(OFS_CH3_HIGH, {2'b00, r[9:8], 2'b00, d[9:8]});
      wr(b + OFS_RELOAD, r[7:0]);
      wr(b + OFS_DUTY, d[7:0]);
   endtask

   // counts high samples and level changes of the channel two pin
   task automatic watch(input int cyc);
      logic prev;
      hi = 0;
      tg = 0;
      @(posedge ref_clk);
      prev = ch2_pin;
      repeat (cyc) begin
         @(posedge ref_clk);
         if (ch2_pin === 1'b1) hi++;
         if (ch2_pin !== prev) tg++;
         prev = ch2_pin;
      end
   endtask

   // pin changes slowly so the two-flop synchroniser sees every edge
   task automatic set_pin(input logic v);
      @(posedge ref_clk);
      ext_count_pin <= v;
      repeat (6) @(posedge ref_clk);
   endtask

   initial begin
      repeat (12) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      check("ch2_pin_oe_n", ch2_pin_oe_n, 1'h1);
      check("ch2_irq", ch2_irq, 1'h0);
      // refused accesses leave state alone
      wr(OFS_CTRL_B, 8'h08);
      bus(1'b1, OFS_CTRL_B, 8'h3F, 4'h0);
      rd(OFS_CTRL_B);
      check("masked write", q, 32'h0000_0008);
      rd(7'h60);
      check("unmapped read", q, 32'h0000_0000);
      // disabled channel: low write loads the counter at once
      load(7'h00, 10'h2C5, 10'h000);
      rd(OFS_RELOAD);
      check("ch2 count", q[9:0], 10'h2C5);
      repeat (10) @(posedge ref_clk);
      rd(OFS_RELOAD);
      check("ch2 idle count", q[9:0], 10'h2C5);
      load(7'h20, 10'h1F2, 10'h000);
      rd(7'h20 + OFS_RELOAD);
      check("ch3 count", q[9:0], 10'h1F2);
      // free run from all ones, then reload taken only at underflow
      load(7'h00, 10'h003, 10'h000);
      wr(OFS_CTRL_A, 8'h01);
      repeat (20) @(posedge ref_clk);
      rd(OFS_RELOAD);
      check("restart all ones", q[9:0] > 10'h3E0, 1'h1);
      load(7'h00, 10'h007, 10'h000);
      rd(OFS_RELOAD);
      check("no early reload", q[9:0] > 10'h300, 1'h1);
      wr(OFS_CTRL_A, 8'h03);
      repeat (1100) @(posedge ref_clk);
      rd(OFS_RELOAD);
      check("restart at reload", q[9:0] <= 10'h007, 1'h1);
      // one shot, flag and interrupt gating
      wr(OFS_CTRL_A, 8'h00);
      load(7'h00, 10'h005, 10'h000);
      wr(OFS_IRQ_FLAG, 8'h00);
      wr(OFS_CTRL_A, 8'h05);
      repeat (20) @(posedge ref_clk);
      rd(OFS_RELOAD);
      check("one shot stop", q[9:0], 10'h000);
      rd(OFS_IRQ_FLAG);
      check("ch2 flag", q[IRQ2_FLAG], 1'h1);
      check("ch2_irq masked", ch2_irq, 1'h0);
      wr(OFS_IRQ_EN, 8'hA0);
      repeat (3) @(posedge ref_clk);
      check("ch2_irq", ch2_irq, 1'h1);
      wr(OFS_IRQ_EN, 8'h20);
      repeat (3) @(posedge ref_clk);
      check("ch2_irq no gie", ch2_irq, 1'h0);
      wr(OFS_IRQ_EN, 8'hA0);
      wr(OFS_IRQ_FLAG, 8'h00);
      rd(OFS_IRQ_FLAG);
      check("ch2 flag cleared", q[IRQ2_FLAG], 1'h0);
      check("ch2_irq cleared", ch2_irq, 1'h0);
      // channel three flag lives in the second register
      load(7'h20, 10'h002, 10'h000);
      wr(7'h20 + OFS_CTRL_B, 8'h08);
      wr(OFS_IRQ_SECOND, 8'h01);
      wr(7'h20 + OFS_CTRL_A, 8'h05);
      repeat (10) @(posedge ref_clk);
      rd(OFS_IRQ_SECOND);
      check("ch3 flag", q[IRQ3_FLAG], 1'h1);
      check("ch3_irq", ch3_irq, 1'h1);
      wr(OFS_IRQ_SECOND, 8'h01);
      repeat (3) @(posedge ref_clk);
      check("ch3_irq cleared", ch3_irq, 1'h0);
      // external pin edges, then fast oscillator
      wr(7'h20 + OFS_CTRL_A, 8'h00);
      load(7'h20, 10'h032, 10'h000);
      wr(7'h20 + OFS_CTRL_B, 8'h28);
      wr(7'h20 + OFS_CTRL_A, 8'h01);
      set_pin(1'b1);
      set_pin(1'b0);
      rd(7'h20 + OFS_RELOAD);
      check("rising edges", q[9:0], 10'h031);
      wr(7'h20 + OFS_CTRL_B, 8'h38);
      set_pin(1'b1);
      set_pin(1'b0);
      rd(7'h20 + OFS_RELOAD);
      check("falling edges", q[9:0], 10'h030);
      wr(7'h20 + OFS_CTRL_A, 8'h09);
      repeat (8) begin
         @(posedge ref_clk);
         internal_fast_osc <= ~internal_fast_osc;
         repeat (3) @(posedge ref_clk);
      end
      repeat (6) @(posedge ref_clk);
      rd(7'h20 + OFS_RELOAD);
      check("fast osc ticks", q[9:0], 10'h02C);
      wr(7'h20 + OFS_CTRL_A, 8'h00);
      // half step on ch3: period four osc ticks, duty one; window skips the first two periods
      for (int h = 0; h < 2; h++) begin
         load(7'h20, 10'h003, 10'h001);
         wr(7'h20 + OFS_CTRL_B, h ? 8'h48 : 8'h08);
         wr(7'h20 + OFS_CTRL_A, 8'h8B);
         hi = 0;
         fork
            repeat (48) begin
               @(posedge ref_clk);
               internal_fast_osc <= ~internal_fast_osc;
               repeat (3) @(posedge ref_clk);
            end
            begin
               repeat (64) @(posedge ref_clk);
               repeat (128) begin
                  @(posedge ref_clk);
                  if (ch3_pin === 1'b1) hi++;
               end
            end
         join
         check("half step high clocks", hi, h ? 48 : 32);
         check("ch3_pin_oe_n", ch3_pin_oe_n, 1'h0);
         wr(7'h20 + OFS_CTRL_A, 8'h00);
      end
      // ratios 0 to 2 each give about ten ticks in ten divided periods
      for (int r = 0; r < 3; r++) begin
         wr(OFS_CTRL_A, 8'h00);
         load(7'h00, 10'h064, 10'h000);
         wr(OFS_CTRL_B, 8'(r));
         wr(OFS_CTRL_A, 8'h01);
         repeat ((10 << (r + 1)) - 3) @(posedge ref_clk);
         rd(OFS_RELOAD);
         cnt = 100 - int'(q[9:0]);
         check("prescaled ticks", cnt >= 9 && cnt <= 11, 1'h1);
         rd(OFS_PSC);
         prev_q = q;
         rd(OFS_PSC);
         check("prescale count live", q !== prev_q, 1'h1);
      end
      // pwm period ten, duty three; 40 samples span four whole periods
      wr(OFS_CTRL_A, 8'h00);
      wr(OFS_CTRL_B, 8'h08);
      load(7'h00, 10'h009, 10'h003);
      wr(OFS_CTRL_A, 8'h83);
      repeat (30) @(posedge ref_clk);
      watch(40);
      check("pwm high clocks", hi, 12);
      check("ch2_pin_oe_n", ch2_pin_oe_n, 1'h0);
      wr(OFS_CTRL_A, 8'hC3);
      repeat (20) @(posedge ref_clk);
      watch(40);
      check("pwm active low", hi, 28);
      load(7'h00, 10'h009, 10'h000);
      rd(OFS_DUTY);
      check("pending duty", q[9:0], 10'h000);
      repeat (30) @(posedge ref_clk);
      watch(40);
      check("duty zero", hi, 40);
      // tone on the same pin loses to pwm
      wr(OFS_TONE, 8'h88);
      wr(OFS_CTRL_A, 8'h83);
      repeat (20) @(posedge ref_clk);
      watch(40);
      check("pwm priority", hi, 0);
      wr(OFS_CTRL_A, 8'h03);
      repeat (30) @(posedge ref_clk);
      watch(80);
      check("tone toggles", tg, 8);
      check("tone oe_n", ch2_pin_oe_n, 1'h0);
      wr(OFS_TONE, 8'h89);
      repeat (40) @(posedge ref_clk);
      watch(80);
      check("tone halved", tg, 4);
      wr(OFS_TONE, 8'h00);
      repeat (3) @(posedge ref_clk);
      check("pin released", ch2_pin_oe_n, 1'h1);
      wrap_up();
   end
endmodule
